// File: verilog/adcsp_device.sv
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "adcsp_params.svh"
module adcsp_device (
  input wire logic pclk,
  input wire logic presetn,
  adcsp_link_if.device link,
  input wire logic [15:0] result_data,
  input wire logic result_strobe,
  output logic [1:0] gain,
  output logic standby,
  output logic [7:0] setup_cfg,
  output logic cal_start
);
  import adcsp_pkg::*;

  adcsp_phase_type phase_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] shift_in_reg;
  logic [7:0] comm_reg;
  logic [7:0] setup_reg;
  logic [5:0] ones_reg;
  logic [15:0] read_word_reg;
  logic [15:0] data_hold_reg;
  logic drive_reg;
  logic [4:0] read_len_reg;
  logic read_done_tgl_reg;
  logic cfg_tgl_reg;
  logic cal_tgl_reg;
  logic dout_reg;
  logic sel;
  logic bit_in;
  logic [7:0] byte_next;
  logic byte_last;
  logic read_last;
  logic ifreset_hit;
  logic rdy_n_s;
  adcsp_rs_type rs_next;
  adcsp_rs_type rs_cur;

  assign sel = ~link.cs_n;
  assign bit_in = link.data_line;
  assign byte_next = {shift_in_reg[6:0], bit_in};
  assign byte_last = (bit_cnt_reg == 5'(`ADCSP_BYTE_BITS - 1));
  assign read_last = (bit_cnt_reg == read_len_reg - 5'd1);
  assign ifreset_hit = bit_in & (ones_reg == 6'(`ADCSP_IFRESET_ONES - 1));
  assign rs_next = adcsp_rs_type'(byte_next[`ADCSP_COMM_RS +: 2]);
  assign rs_cur = adcsp_rs_type'(comm_reg[`ADCSP_COMM_RS +: 2]);

  // ready level brought into the link domain for the status bit
  adcsp_sync2 u_rdy_sync (
    .clk(link.sclk),
    .rst_n(presetn),
    .d(link.conversion_ready_n),
    .q(rdy_n_s)
  );

  // input shift, sampled on rising link edges
  always_ff @(posedge link.sclk or negedge presetn) begin // see [RULE19]
    if (!presetn) begin
      shift_in_reg <= 8'h00;
    end else if (sel) begin
      shift_in_reg <= byte_next;
    end
  end

  // run of ones on the data input; counted in every phase so a lost link recovers
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      ones_reg <= 6'h00;
    end else if (sel) begin
      if (!bit_in || ifreset_hit) begin
        ones_reg <= 6'h00;
      end else begin
        ones_reg <= ones_reg + 6'd1;
      end
    end
  end

  // phase sequencer; the selected operation follows the eighth clock directly
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= ADCSP_P_COMM;
      bit_cnt_reg <= 5'h00;
    end else if (sel) begin
      if (ifreset_hit) begin
        phase_reg <= ADCSP_P_COMM; // see [RULE16]
        bit_cnt_reg <= 5'h00;
      end else begin
        case (phase_reg)
          ADCSP_P_COMM: begin
            if (byte_last) begin
              bit_cnt_reg <= 5'h00;
              phase_reg <= byte_next[`ADCSP_COMM_RW] ? ADCSP_P_READ : ADCSP_P_WRITE; // see [RULE15]
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 5'd1;
            end
          end
          ADCSP_P_WRITE: begin
            if (byte_last) begin
              bit_cnt_reg <= 5'h00;
              phase_reg <= ADCSP_P_COMM;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 5'd1;
            end
          end
          ADCSP_P_READ: begin
            if (read_last) begin
              bit_cnt_reg <= 5'h00;
              phase_reg <= ADCSP_P_COMM;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 5'd1;
            end
          end
          default: begin
            phase_reg <= ADCSP_P_COMM;
            bit_cnt_reg <= 5'h00;
          end
        endcase
      end
    end
  end

  // register writes; input bits during a read never reach here
  always_ff @(posedge link.sclk or negedge presetn) begin // see [RULE2]
    if (!presetn) begin
      comm_reg <= `ADCSP_COMM_RESET;
      setup_reg <= `ADCSP_SETUP_RESET;
      cfg_tgl_reg <= 1'b0;
      cal_tgl_reg <= 1'b0;
    end else if (sel && !ifreset_hit && byte_last) begin
      if (phase_reg == ADCSP_P_COMM) begin
        comm_reg <= {1'b0, byte_next[6:0]}; // see [RULE10] [RULE12]
        cfg_tgl_reg <= ~cfg_tgl_reg;
      end else if (phase_reg == ADCSP_P_WRITE && rs_cur == ADCSP_RS_SETUP) begin
        setup_reg <= byte_next; // see [RULE11]
        cfg_tgl_reg <= ~cfg_tgl_reg;
        if (byte_next[`ADCSP_SETUP_MD +: 2] == `ADCSP_MD_SELFCAL) begin
          cal_tgl_reg <= ~cal_tgl_reg;
        end
      end
    end
  end

  // read word loaded left aligned when a read is selected
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      read_word_reg <= `ADCSP_DATA_RESET;
      read_len_reg <= 5'(`ADCSP_BYTE_BITS);
    end else if (sel && !ifreset_hit && byte_last && phase_reg == ADCSP_P_COMM &&
                 byte_next[`ADCSP_COMM_RW]) begin
      case (rs_next)
        ADCSP_RS_COMM: begin
          read_word_reg <= {rdy_n_s, byte_next[6:0], 8'h00}; // see [RULE18] [RULE4]
          read_len_reg <= 5'(`ADCSP_BYTE_BITS);
        end
        ADCSP_RS_SETUP: begin
          read_word_reg <= {setup_reg, 8'h00};
          read_len_reg <= 5'(`ADCSP_BYTE_BITS);
        end
        ADCSP_RS_DATA: begin
          read_word_reg <= data_hold_reg; // stable while ready is low
          read_len_reg <= 5'(`ADCSP_DATA_BITS); // see [RULE12]
        end
        default: begin
          read_word_reg <= 16'h0000;
          read_len_reg <= 5'(`ADCSP_BYTE_BITS);
        end
      endcase
    end
  end

  // end of a data read, reported to the core domain
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      read_done_tgl_reg <= 1'b0;
    end else if (sel && !ifreset_hit && phase_reg == ADCSP_P_READ && read_last &&
                 rs_cur == ADCSP_RS_DATA) begin
      read_done_tgl_reg <= ~read_done_tgl_reg;
    end
  end

  // output bit changes on falling edges, msb first
  always_ff @(negedge link.sclk or negedge presetn) begin // see [RULE19]
    if (!presetn) begin
      dout_reg <= 1'b1;
    end else begin
      dout_reg <= read_word_reg[4'hf - bit_cnt_reg[3:0]]; // see [RULE3]
    end
  end

  // enable waits for the first falling edge of a read, so a host still holding
  // the shared line after its last write bit never meets the device on it
  always_ff @(negedge link.sclk or negedge presetn) begin // see [RULE7]
    if (!presetn) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= (phase_reg == ADCSP_P_READ);
    end
  end

  // drive only while reading and selected
  assign link.miso = dout_reg;
  assign link.miso_oe = sel & drive_reg & (phase_reg == ADCSP_P_READ); // see [RULE1] [RULE7]

  // core domain: crossings back from the link
  logic rd_done_s;
  logic cfg_s;
  logic cal_s;
  logic rd_done_d_reg;
  logic cfg_d_reg;
  logic cal_d_reg;
  logic [15:0] latch_reg;
  logic pend_reg;
  logic rdy_n_reg;

  adcsp_sync2 u_done_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(read_done_tgl_reg),
    .q(rd_done_s)
  );
  adcsp_sync2 u_cfg_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(cfg_tgl_reg),
    .q(cfg_s)
  );
  adcsp_sync2 u_cal_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(cal_tgl_reg),
    .q(cal_s)
  );

  // toggle edge detectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_done_d_reg <= 1'b0;
      cfg_d_reg <= 1'b0;
      cal_d_reg <= 1'b0;
    end else begin
      rd_done_d_reg <= rd_done_s;
      cfg_d_reg <= cfg_s;
      cal_d_reg <= cal_s;
    end
  end

  // config copied once the toggle lands; link regs are quiet for many pclk by then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain <= 2'h0;
      standby <= 1'b0;
      setup_cfg <= `ADCSP_SETUP_RESET;
      cal_start <= 1'b0;
    end else begin
      cal_start <= cal_s ^ cal_d_reg; // see [RULE11]
      if (cfg_s ^ cfg_d_reg) begin
        gain <= comm_reg[`ADCSP_COMM_GAIN +: 2]; // see [RULE10]
        standby <= comm_reg[`ADCSP_COMM_STBY];
        setup_cfg <= setup_reg;
      end
    end
  end

  // ready goes high a cycle before the word changes, low once it has
  always_ff @(posedge pclk or negedge presetn) begin // see [RULE17]
    if (!presetn) begin
      latch_reg <= `ADCSP_DATA_RESET;
      data_hold_reg <= `ADCSP_DATA_RESET;
      pend_reg <= 1'b0;
      rdy_n_reg <= 1'b1;
    end else if (result_strobe) begin
      latch_reg <= result_data;
      pend_reg <= 1'b1;
      rdy_n_reg <= 1'b1;
    end else if (pend_reg) begin
      data_hold_reg <= latch_reg;
      pend_reg <= 1'b0;
      rdy_n_reg <= 1'b0;
    end else if (rd_done_s ^ rd_done_d_reg) begin
      rdy_n_reg <= 1'b1;
    end
  end

  assign link.conversion_ready_n = rdy_n_reg;
endmodule
`default_nettype wire

// File: shared/adcsp_params.svh
`ifndef ADCSP_PARAMS_SVH
`define ADCSP_PARAMS_SVH

// host register byte offsets on apb
`define ADCSP_CTRL_OFF 8'h00
`define ADCSP_TXDATA_OFF 8'h04
`define ADCSP_RXDATA_OFF 8'h08
`define ADCSP_STATUS_OFF 8'h0c

// host ctrl fields
`define ADCSP_CTRL_GO 0
`define ADCSP_CTRL_READ 1
`define ADCSP_CTRL_LEN 2
`define ADCSP_CTRL_LSB 4
`define ADCSP_CTRL_WAITRDY 5
`define ADCSP_CTRL_CSTIED 6
`define ADCSP_CTRL_RESET 6'h00

// host status fields
`define ADCSP_STAT_BUSY 0
`define ADCSP_STAT_DONE 1
`define ADCSP_STAT_RDYN 2

// serial clock: host clock rate and the highest link rate, in mhz
`define ADCSP_PCLK_MHZ 200
`define ADCSP_SCLK_MAX_MHZ 3
// half period in pclk cycles, rounded up so the link never runs too fast
`define ADCSP_SCLK_HALF ((`ADCSP_PCLK_MHZ + 2 * `ADCSP_SCLK_MAX_MHZ - 1) / (2 * `ADCSP_SCLK_MAX_MHZ))

// device link counts
`define ADCSP_IFRESET_ONES 32
`define ADCSP_BYTE_BITS 8
`define ADCSP_DATA_BITS 16

// device communications register fields
`define ADCSP_COMM_RDY 7
`define ADCSP_COMM_RS 4
`define ADCSP_COMM_RW 3
`define ADCSP_COMM_STBY 2
`define ADCSP_COMM_GAIN 0
`define ADCSP_COMM_RESET 8'h00

// device setup register fields
`define ADCSP_SETUP_MD 6
`define ADCSP_MD_SELFCAL 2'h1
`define ADCSP_SETUP_RESET 8'h00
`define ADCSP_DATA_RESET 16'h0000

// documented power-up command bytes
`define ADCSP_CMD_WR_SETUP 8'h10
`define ADCSP_CMD_SETUP_60HZ 8'h68
`define ADCSP_CMD_RD_DATA 8'h38

`endif

// File: shared/adcsp_pkg.sv
package adcsp_pkg;
  // device register select codes
  typedef enum logic [1:0] {
    ADCSP_RS_COMM = 2'h0,
    ADCSP_RS_SETUP = 2'h1,
    ADCSP_RS_TEST = 2'h2,
    ADCSP_RS_DATA = 2'h3
  } adcsp_rs_type;

  // device link phase
  typedef enum logic [2:0] {
    ADCSP_P_COMM = 3'b001,
    ADCSP_P_WRITE = 3'b010,
    ADCSP_P_READ = 3'b100
  } adcsp_phase_type;

  // host transfer length
  typedef enum logic [1:0] {
    ADCSP_LEN8 = 2'h0,
    ADCSP_LEN16 = 2'h1,
    ADCSP_LEN24 = 2'h2,
    ADCSP_LEN32 = 2'h3
  } adcsp_len_type;

  // host sequencer
  typedef enum logic [3:0] {
    ADCSP_S_IDLE = 4'b0001,
    ADCSP_S_WAIT = 4'b0010,
    ADCSP_S_SHIFT = 4'b0100,
    ADCSP_S_END = 4'b1000
  } adcsp_hstate_type;
endpackage

// File: shared/adcsp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcsp_link_if;
  logic sclk;
  logic cs_n;
  logic receive_frame_sync_n;
  logic transmit_frame_sync_n;
  logic mosi;
  logic mosi_oe;
  logic miso;
  logic miso_oe;
  logic conversion_ready_n;
  logic data_line;

  // one shared data wire with pull-up; separate wires behave the same when half duplex
  assign data_line = mosi_oe ? mosi : (miso_oe ? miso : 1'b1);

  modport host (
    output sclk,
    output cs_n,
    output receive_frame_sync_n,
    output transmit_frame_sync_n,
    output mosi,
    output mosi_oe,
    input data_line,
    input conversion_ready_n
  );

  modport device (
    input sclk,
    input cs_n,
    input data_line,
    output miso,
    output miso_oe,
    output conversion_ready_n
  );
endinterface
`default_nettype wire

// File: verilog/adcsp_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module adcsp_sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_reg;

  // two stages; only the second is visible outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// File: verilog/adcsp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcsp_params.svh"
// Contract
// [RULE1] device leaves output undriven during writes
// [RULE2] device ignores input during reads
// [RULE3] device shifts reads msb first
// [RULE4] three-wire host polls comm ready bit
// [RULE5] host clock idles high, mode three
// [RULE6] host may poll ready line instead
// [RULE7] shared line: each drives own phase
// [RULE8] host serial clock at most 3 mhz
// [RULE9] select active while either frame sync active
// [RULE10] comm byte 0x10 selects setup write
// [RULE11] setup byte 0x68 configures, starts calibration
// [RULE12] comm byte 0x38 selects 16-bit data read
// [RULE13] host waits for ready before reading
// [RULE14] lsb-first hosts reverse each byte
// [RULE15] operation follows eighth comm clock directly
// [RULE16] 32 ones reset the interface
// [RULE17] ready low on result, high after read
// [RULE18] ready shown as comm register msb
// [RULE19] output on falling, sample on rising edge
module adcsp_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  adcsp_link_if.host link
);
  import adcsp_pkg::*;

  adcsp_hstate_type state_reg;
  logic [6:1] ctrl_reg;
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic [31:0] tx_shift_reg;
  logic [31:0] rx_shift_reg;
  logic [31:0] prdata_reg;
  logic [5:0] half_cnt_reg;
  logic [5:0] bits_left_reg;
  logic done_reg;
  logic sclk_reg;
  logic mosi_reg;
  logic mosi_oe_reg;
  logic rfs_n_reg;
  logic tfs_n_reg;
  logic miso_s;
  logic rdy_n_s;
  logic apb_wr;
  logic apb_setup_rd;
  logic addr_hit;
  logic idle;
  logic go_req;
  logic half_done;
  logic done_set;
  logic [31:0] tx_rev;
  logic [31:0] rx_rev;
  adcsp_len_type start_len;

  // transfer length in bits
  function automatic logic [5:0] adcsp_nbits(input adcsp_len_type len);
    case (len)
      ADCSP_LEN8: adcsp_nbits = 6'd8;
      ADCSP_LEN16: adcsp_nbits = 6'd16;
      ADCSP_LEN24: adcsp_nbits = 6'd24;
      default: adcsp_nbits = 6'd32;
    endcase
  endfunction

  // move the low bits to the top so the shifter always sends bit 31 first
  function automatic logic [31:0] adcsp_align(input logic [31:0] d, input adcsp_len_type len);
    case (len)
      ADCSP_LEN8: adcsp_align = {d[7:0], 24'h000000};
      ADCSP_LEN16: adcsp_align = {d[15:0], 16'h0000};
      ADCSP_LEN24: adcsp_align = {d[23:0], 8'h00};
      default: adcsp_align = d;
    endcase
  endfunction

  // pins from the far end pass two flops first
  adcsp_sync2 u_miso_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.data_line),
    .q(miso_s)
  );
  adcsp_sync2 u_rdy_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.conversion_ready_n),
    .q(rdy_n_s)
  );

  // bit order swap within every byte
  for (genvar i = 0; i < 32; i++) begin : g_rev
    assign tx_rev[i] = tx_reg[(i / 8) * 8 + 7 - (i % 8)]; // see [RULE14]
    assign rx_rev[i] = rx_shift_reg[(i / 8) * 8 + 7 - (i % 8)];
  end

  // apb decode; every access completes in one access cycle
  assign apb_wr = psel & penable & pwrite;
  assign apb_setup_rd = psel & ~penable & ~pwrite;
  assign addr_hit = (paddr == `ADCSP_CTRL_OFF) || (paddr == `ADCSP_TXDATA_OFF) ||
                    (paddr == `ADCSP_RXDATA_OFF) || (paddr == `ADCSP_STATUS_OFF);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata = prdata_reg;
  assign idle = (state_reg == ADCSP_S_IDLE);
  assign go_req = apb_wr & (paddr == `ADCSP_CTRL_OFF) & pwdata[`ADCSP_CTRL_GO] & idle;
  assign start_len = adcsp_len_type'(pwdata[`ADCSP_CTRL_LEN +: 2]);
  assign half_done = (half_cnt_reg == 6'(`ADCSP_SCLK_HALF - 1));
  assign done_set = (state_reg == ADCSP_S_END) && half_done;

  // read data captured in the setup cycle, valid through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (apb_setup_rd) begin
      case (paddr)
        `ADCSP_CTRL_OFF: prdata_reg <= {25'h0000000, ctrl_reg, 1'b0};
        `ADCSP_TXDATA_OFF: prdata_reg <= tx_reg;
        `ADCSP_RXDATA_OFF: prdata_reg <= rx_reg;
        `ADCSP_STATUS_OFF: prdata_reg <= {29'h00000000, rdy_n_s, done_reg, ~idle}; // see [RULE6]
        default: prdata_reg <= 32'h00000000;
      endcase
    end
  end

  // config and transmit word; writes refused while a transfer runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `ADCSP_CTRL_RESET;
      tx_reg <= 32'h00000000;
    end else if (apb_wr && idle) begin
      if (paddr == `ADCSP_CTRL_OFF) begin
        ctrl_reg <= pwdata[6:1];
      end
      if (paddr == `ADCSP_TXDATA_OFF) begin
        tx_reg <= pwdata;
      end
    end
  end

  // done flag: set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (done_set) begin
      done_reg <= 1'b1;
    end else if (go_req) begin
      done_reg <= 1'b0;
    end else if (apb_wr && paddr == `ADCSP_STATUS_OFF && pwdata[`ADCSP_STAT_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  // sequencer: optional wait for ready, bit shifting, closing half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ADCSP_S_IDLE;
    end else begin
      case (state_reg)
        ADCSP_S_IDLE: begin
          if (go_req) begin
            state_reg <= pwdata[`ADCSP_CTRL_WAITRDY] ? ADCSP_S_WAIT : ADCSP_S_SHIFT;
          end
        end
        ADCSP_S_WAIT: begin
          if (!rdy_n_s) begin
            state_reg <= ADCSP_S_SHIFT; // see [RULE13]
          end
        end
        ADCSP_S_SHIFT: begin
          if (half_done && !sclk_reg && bits_left_reg == 6'd1) begin
            state_reg <= ADCSP_S_END;
          end
        end
        ADCSP_S_END: begin
          if (half_done) begin
            state_reg <= ADCSP_S_IDLE;
          end
        end
        default: state_reg <= ADCSP_S_IDLE;
      endcase
    end
  end

  // half period divider; the link rate stays at or under its limit
  always_ff @(posedge pclk or negedge presetn) begin // see [RULE8]
    if (!presetn) begin
      half_cnt_reg <= 6'h00;
    end else if (state_reg == ADCSP_S_SHIFT || state_reg == ADCSP_S_END) begin
      half_cnt_reg <= half_done ? 6'h00 : half_cnt_reg + 6'd1;
    end else begin
      half_cnt_reg <= 6'h00;
    end
  end

  // clock and data: change on falling, sample on rising, rest high
  always_ff @(posedge pclk or negedge presetn) begin // see [RULE5]
    if (!presetn) begin
      sclk_reg <= 1'b1;
      mosi_reg <= 1'b1;
      tx_shift_reg <= 32'h00000000;
      rx_shift_reg <= 32'h00000000;
      bits_left_reg <= 6'h00;
    end else if (go_req) begin
      sclk_reg <= 1'b1;
      tx_shift_reg <= adcsp_align(pwdata[`ADCSP_CTRL_LSB] ? tx_rev : tx_reg, start_len);
      rx_shift_reg <= 32'h00000000;
      bits_left_reg <= adcsp_nbits(start_len);
    end else if (state_reg == ADCSP_S_SHIFT && half_done) begin
      if (sclk_reg) begin
        sclk_reg <= 1'b0;
        mosi_reg <= tx_shift_reg[31];
        tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
      end else begin
        sclk_reg <= 1'b1;
        rx_shift_reg <= {rx_shift_reg[30:0], miso_s};
        bits_left_reg <= bits_left_reg - 6'd1;
      end
    end
  end

  // received word, bit order swapped within each byte for lsb-first software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_reg <= 32'h00000000;
    end else if (done_set && ctrl_reg[`ADCSP_CTRL_READ]) begin
      rx_reg <= ctrl_reg[`ADCSP_CTRL_LSB] ? rx_rev : rx_shift_reg; // see [RULE14]
    end
  end

  // frame syncs per direction; host drives the data line only while writing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rfs_n_reg <= 1'b1;
      tfs_n_reg <= 1'b1;
      mosi_oe_reg <= 1'b0;
    end else if (go_req) begin
      rfs_n_reg <= ~pwdata[`ADCSP_CTRL_READ] | pwdata[`ADCSP_CTRL_WAITRDY];
      tfs_n_reg <= pwdata[`ADCSP_CTRL_READ] | pwdata[`ADCSP_CTRL_WAITRDY];
      mosi_oe_reg <= ~pwdata[`ADCSP_CTRL_READ] & ~pwdata[`ADCSP_CTRL_WAITRDY]; // see [RULE7]
    end else if (state_reg == ADCSP_S_WAIT && !rdy_n_s) begin
      rfs_n_reg <= ~ctrl_reg[`ADCSP_CTRL_READ];
      tfs_n_reg <= ctrl_reg[`ADCSP_CTRL_READ];
      mosi_oe_reg <= ~ctrl_reg[`ADCSP_CTRL_READ];
    end else if (done_set) begin
      rfs_n_reg <= 1'b1;
      tfs_n_reg <= 1'b1;
      mosi_oe_reg <= 1'b0;
    end
  end

  // select is the and of the low-true frame syncs, or held low in three-wire mode
  assign link.cs_n = ctrl_reg[`ADCSP_CTRL_CSTIED] ? 1'b0 : (rfs_n_reg & tfs_n_reg); // see [RULE9] [RULE4]
  assign link.receive_frame_sync_n = rfs_n_reg;
  assign link.transmit_frame_sync_n = tfs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.mosi = mosi_reg;
  assign link.mosi_oe = mosi_oe_reg;
endmodule
`default_nettype wire

// File: test/adcsp_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module adcsp_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic receive_frame_sync_n,
  input wire logic transmit_frame_sync_n,
  input wire logic mosi_oe,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic conversion_ready_n
);
  logic sclk_reg;
  logic [7:0] hold_reg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since sclk last moved, saturating so idle gaps never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_reg <= 1'b1;
      hold_reg <= 8'h00;
    end else begin
      sclk_reg <= sclk;
      hold_reg <= (sclk != sclk_reg) ? 8'h00 : hold_reg + {7'h00, hold_reg != 8'hff};
    end
  end
  a_sclk_idle: assert property (cs_n |-> sclk)
    else $error("sclk low while deselected");
  a_start_high: assert property ($fell(cs_n) |-> sclk [*8])
    else $error("frame starts without high clock lead");
  a_end_high: assert property ($rose(cs_n) |-> sclk && $past(sclk, 8))
    else $error("frame ends without high clock tail");
  a_no_clash: assert property (!(mosi_oe && miso_oe))
    else $error("both ends drive the data line");
  a_miso_sel: assert property (miso_oe |-> !cs_n)
    else $error("device drives while deselected");
  a_miso_fall: assert property ($changed(miso) |-> !sclk)
    else $error("device output moved while clock high");
  a_oe_rise: assert property ($rose(miso_oe) |-> !sclk && !mosi_oe)
    else $error("device output enabled at wrong point");
  a_fsync_sel: assert property (!(receive_frame_sync_n && transmit_frame_sync_n) |-> !cs_n)
    else $error("frame sync active without select");
  a_half_period: assert property (sclk != sclk_reg |-> hold_reg >= 8'h21)
    else $error("serial clock half period too short");
  c_read: cover property ($rose(miso_oe));
  c_ready: cover property ($fell(conversion_ready_n));
  c_frame: cover property ($rose(cs_n));
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcsp_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rstrobe = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, perr, cal_start, standby;
  logic [15:0] rdata = 16'h0;
  logic [1:0] gain;
  logic [7:0] setup_cfg;
  int n_mismatch = 0, cmp_count = 0, n_cal = 0, cyc = 0;
  adcsp_link_if lnk();
  adcsp_host i_adcsp_host(.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(lnk));
  adcsp_device i_adcsp_device(.pclk(pclk), .presetn(presetn), .link(lnk),
    .result_data(rdata), .result_strobe(rstrobe), .gain(gain), .standby(standby),
    .setup_cfg(setup_cfg), .cal_start(cal_start));
  adcsp_link_props i_props(.pclk(pclk), .presetn(presetn), .sclk(lnk.sclk),
    .cs_n(lnk.cs_n), .receive_frame_sync_n(lnk.receive_frame_sync_n),
    .transmit_frame_sync_n(lnk.transmit_frame_sync_n), .mosi_oe(lnk.mosi_oe),
    .miso(lnk.miso), .miso_oe(lnk.miso_oe), .conversion_ready_n(lnk.conversion_ready_n));
  // 200 mhz core clock
  initial forever #2.5 pclk = ~pclk;
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog, plus a count of calibration pulses
  always @(posedge pclk) begin
    cyc++;
    if (cal_start === 1'b1)
      n_cal++;
    if (cyc == 50000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // one apb transfer; waits on pready rather than assuming zero wait states
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one link frame; the watchdog bounds the poll on done
  task automatic xfer(input logic [6:0] c, input logic [31:0] tx);
    apb(1'b1, `ADCSP_TXDATA_OFF, tx);
    apb(1'b1, `ADCSP_CTRL_OFF, {25'h0, c | 7'h01});
    do apb(1'b0, `ADCSP_STATUS_OFF, 32'h0); while (rd[`ADCSP_STAT_DONE] !== 1'b1);
    apb(1'b0, `ADCSP_RXDATA_OFF, 32'h0);
  endtask
  // new conversion result, then time for the ready line to cross
  task automatic res(input logic [15:0] v);
    @(posedge pclk);
    rdata <= v;
    rstrobe <= 1'b1;
    @(posedge pclk);
    rstrobe <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  // three-wire poll: select held low, command byte then status byte
  task automatic comm_rd(input logic e);
    xfer(7'h40, 32'h08);
    xfer(7'h42, 32'h0);
    `CHK("comm ready", e, rd[7])
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ADCSP_CTRL_OFF, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    apb(1'b0, `ADCSP_STATUS_OFF, 32'h0);
    `CHK("status", 32'h4, rd)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("slverr", 1'b1, perr)
    $display("test reset done");
    // gain sweep: command and setup byte in one frame, no gap between
    for (int g = 3; g >= 0; g--) begin
      xfer(7'h04, {16'h0, 8'h10 | 8'(g), 8'h68});
      `CHK("gain", 2'(g), gain)
      `CHK("standby", 1'b0, standby)
      `CHK("setup", 8'h68, setup_cfg)
    end
    `CHK("cal", 4, n_cal)
    $display("test config done");
    res(16'ha5c3);
    apb(1'b0, `ADCSP_STATUS_OFF, 32'h0);
    `CHK("rdyn low", 1'b0, rd[2])
    comm_rd(1'b0);
    xfer(7'h00, 32'h38);
    xfer(7'h26, 32'h0);
    `CHK("data", 32'ha5c3, rd)
    repeat (4) @(posedge pclk);
    apb(1'b0, `ADCSP_STATUS_OFF, 32'h0);
    `CHK("rdyn high", 1'b1, rd[2])
    comm_rd(1'b1);
    $display("test read done");
    // lost interface: pull-up plus all-ones data give 32 high clocks in one read
    res(16'hffff);
    xfer(7'h0e, 32'h0);
    `CHK("ones", 32'hffffffff, rd)
    xfer(7'h04, 32'h1368);
    `CHK("gain resync", 2'h3, gain)
    xfer(7'h14, 32'h8816);
    `CHK("gain lsb", 2'h1, gain)
    $display("test resync done");
    finish_test();
  end
endmodule
`default_nettype wire
